// ### pfr_regs.vh
/*
  Constants for the protection fault reporting block: fault codes, entry bit
  positions, page zero locations and APB register map.
  Assumes inclusion by bare name from the design file.
*/
`ifndef PFR_REGS_VH
`define PFR_REGS_VH
// ----------------------------------------------------------------------------
// Fault codes (the octal codes, written in hex)
// ----------------------------------------------------------------------------
`define PFR_FC_READ        5'h00
`define PFR_FC_WRITE       5'h01
`define PFR_FC_EXEC        5'h02
`define PFR_FC_VALID       5'h03
`define PFR_FC_INWARD_REF  5'h04
`define PFR_FC_DEFER       5'h05
`define PFR_FC_GATE        5'h06
`define PFR_FC_OUT_CALL    5'h07
`define PFR_FC_IN_RET      5'h08
`define PFR_FC_PRIV        5'h09
`define PFR_FC_IO          5'h0a
`define PFR_FC_MICRO_RB    5'h0c
`define PFR_FC_UNIMP       5'h0d
`define PFR_FC_FORM_ID     5'h0f
`define PFR_FC_ATTR        5'h10
`define PFR_FC_BLIT        5'h11
// ----------------------------------------------------------------------------
// Entry bit positions
// ----------------------------------------------------------------------------
`define PFR_ENT_VALID      0
`define PFR_ENT_IO_OK      3
`define PFR_PME_READ       2
`define PFR_PME_WRITE      3
`define PFR_PME_EXEC       4
`define PFR_DEFER_LIMIT    5'h0f
// ----------------------------------------------------------------------------
// Page zero locations (word addresses, octal 0, 1, 30, 32, 34, 36, 47)
// ----------------------------------------------------------------------------
`define PFR_PZ_INT_LEVEL   6'h00
`define PFR_PZ_IO_HANDLER  6'h01
`define PFR_PZ_PF_HANDLER  6'h18
`define PFR_PZ_CTX_BASE    6'h1a
`define PFR_PZ_GATE_ARRAY  6'h1c
`define PFR_PZ_PROT_HANDLR 6'h1e
`define PFR_PZ_LAST        6'h27
`define PFR_NARROW_LIMIT   32'h0000ffff
// ----------------------------------------------------------------------------
// APB register byte addresses
// ----------------------------------------------------------------------------
`define PFR_A_CTRL         12'h000
`define PFR_A_STATUS       12'h004
`define PFR_A_OPC_PC       12'h008
`define PFR_A_OPC_ADDR     12'h00c
`define PFR_A_PZ_BASE      12'h010
`define PFR_A_RB_BASE      12'h020
`define PFR_A_RB_LAST      12'h034
`define PFR_A_UNIMP        12'h040
`define PFR_A_PZ_WORD      12'h044
`define PFR_A_PZ_DATA      12'h048
// CTRL fields
`define PFR_CTRL_XLAT      0
`define PFR_CTRL_CLEAR     1
`endif

// ### pfr_fault_report.v
/*
  Protection fault reporting unit: prioritises fault causes, forms the fault
  code and offending address, builds the six-doubleword return block and
  yields the handler vector location in page zero of segment 0.
  Assumes fault causes arrive as single-cycle pulses with their context and
  that software reads the results over APB.
*/
`timescale 1ns/1ps
`include "pfr_regs.vh"

// ----------------------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------------------
// Overview of operation
// - Load accumulator zero with PC, one with code, two with address if any.
// - Return block words 1-4: status word zero-extended, then accumulators 0,1,2.
// - Word five holds accumulator three; word six carry plus PC for priv/IO.
// - Read, write, execute with map entry bit 2,3,4 clear give codes 0,1,2.
// - Segment or map entry bit 0 clear gives code 3 with address.
// - Data access into inner segment gives code 4 with address.
// - Indirection over fifteen levels gives code 5 with address.
// - Bad gate number or gate bracket on inward call gives code 6.
// - Outward call across segments gives 7; inward return gives octal 10.
// - Privileged instruction outside segment 0 gives code 11, no address.
// - I/O instruction with segment entry bit 3 clear gives code 12.
// - Bad micro-interrupt return block gives code 14; 13 and 16 reserved.
// - Unimplemented opcode gives code 15 without an address.
// - Graphics faults give codes 17, 20 and 21.
// - Every opcode is checked before execution; invalid ones fault.
// - Unimplemented: PC and acc two undefined, except fallback opcode in acc two.
// - Unimplemented faults work untranslated; handler from physical location 36. The code takes the physical handler only with translation off.
// - Words 0 to 47 octal of each page zero are reserved.
// - Handlers direct unless indirectable; narrow pointers stay in first 64K.
// - Translation on: logical page-zero addresses; off: segment 0 physical only.
// - Segment 0 holds handlers at 1, 30, 32, 34 and 36.
// - Page zero word 0 zero means base level, else intermediate.
module pfr_fault_report #(
  parameter OPC_W = 16
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              opc_valid,
  input  wire [OPC_W-1:0]  opc_value,
  input  wire              opc_fallback,
  input  wire              acc_read,
  input  wire              acc_write,
  input  wire              acc_exec,
  input  wire [31:0]       page_map_entry,
  input  wire [31:0]       segment_base_entry,
  input  wire              map_entry_checked,
  input  wire              inner_data_ref,
  input  wire [4:0]        defer_depth,
  input  wire              gate_bad,
  input  wire              outward_call,
  input  wire              inward_return,
  input  wire              priv_instr,
  input  wire [2:0]        cur_segment,
  input  wire              io_instr,
  input  wire              micro_rb_bad,
  input  wire              gfx_form_bad,
  input  wire              gfx_attr_bad,
  input  wire              gfx_blit_bad,
  input  wire [31:0]       fault_pc,
  input  wire [31:0]       fault_addr,
  input  wire [15:0]       processor_status_word,
  input  wire [31:0]       accumulator_three_in,
  input  wire              carry_in,
  output reg               fault_taken,
  output reg  [31:0]       accumulator_zero,
  output reg  [31:0]       accumulator_one,
  output reg  [31:0]       accumulator_two,
  output reg               handler_physical,
  output reg  [5:0]        handler_vector_loc,
  output reg               base_level
);

  // --------------------------------------------------------------------------
  // Opcode validity
  // --------------------------------------------------------------------------
  reg [31:0] unimp_mask_q;

  // Low opcode bits index a software-loaded table of unimplemented groups.
  function opc_bad;
    input [OPC_W-1:0] opc;
    input [31:0]      mask;
    begin
      opc_bad = mask[opc[4:0]];
    end
  endfunction

  // --------------------------------------------------------------------------
  // Fault detection and priority
  // --------------------------------------------------------------------------
  // Priority order follows the processor's fault priority; only the top
  // cause is reported and the rest are dropped.
  reg        hit;
  reg [4:0]  code;
  reg        has_addr;
  always @*
  begin
    hit = 1'b1;
    has_addr = 1'b1;
    code = `PFR_FC_READ;
    if (priv_instr && cur_segment != 3'h0)
    begin
      code = `PFR_FC_PRIV;
      has_addr = 1'b0;
    end
    else if (io_instr && !segment_base_entry[`PFR_ENT_IO_OK])
    begin
      code = `PFR_FC_IO;
      has_addr = 1'b0;
    end
    else if (defer_depth > `PFR_DEFER_LIMIT)
      code = `PFR_FC_DEFER;
    else if (inner_data_ref)
      code = `PFR_FC_INWARD_REF;
    else if (map_entry_checked && (!segment_base_entry[`PFR_ENT_VALID] ||
             !page_map_entry[`PFR_ENT_VALID]))
      code = `PFR_FC_VALID;
    else if (map_entry_checked && acc_read && !page_map_entry[`PFR_PME_READ])
      code = `PFR_FC_READ;
    else if (map_entry_checked && acc_write && !page_map_entry[`PFR_PME_WRITE])
      code = `PFR_FC_WRITE;
    else if (map_entry_checked && acc_exec && !page_map_entry[`PFR_PME_EXEC])
      code = `PFR_FC_EXEC;
    else if (gate_bad)
      code = `PFR_FC_GATE;
    else if (outward_call)
      code = `PFR_FC_OUT_CALL;
    else if (inward_return)
      code = `PFR_FC_IN_RET;
    else
    begin
      has_addr = 1'b0;
      if (micro_rb_bad)
        code = `PFR_FC_MICRO_RB;
      else if (gfx_form_bad)
        code = `PFR_FC_FORM_ID;
      else if (gfx_attr_bad)
        code = `PFR_FC_ATTR;
      else if (gfx_blit_bad)
        code = `PFR_FC_BLIT;
      else if (opc_valid && opc_bad(opc_value, unimp_mask_q))
        code = `PFR_FC_UNIMP;
      else
        hit = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Fault state and return block
  // --------------------------------------------------------------------------
  reg        xlat_on_q;
  reg        pending_q;
  reg [31:0] rb_q [0:5];
  reg [31:0] pz_q [0:7];
  reg [2:0]  pz_idx_q;
  reg [31:0] pc_word;
  reg [31:0] ac2_val;
  integer    i;
  integer    j;

  wire is_priv_io = (code == `PFR_FC_PRIV) || (code == `PFR_FC_IO);
  wire ctrl_wr  = psel && penable && pwrite && (paddr == `PFR_A_CTRL);
  wire do_clear = ctrl_wr && pwdata[`PFR_CTRL_CLEAR];

  always @*
  begin
    // Undefined fields are driven as zero, which is a legal reading of undefined.
    pc_word = {31'h0, carry_in};
    if (is_priv_io)
      pc_word = {fault_pc[31:1], carry_in};
    ac2_val = 32'h0;
    if (has_addr)
      ac2_val = {1'b0, fault_addr[30:0]};
    else if (code == `PFR_FC_UNIMP && opc_fallback)
      ac2_val = {{(32-OPC_W){1'b0}}, opc_value};
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_taken <= 1'b0;
      pending_q <= 1'b0;
      accumulator_zero <= 32'h0;
      accumulator_one <= 32'h0;
      accumulator_two <= 32'h0;
      handler_physical <= 1'b0;
      handler_vector_loc <= `PFR_PZ_PROT_HANDLR;
      for (i = 0; i < 6; i = i + 1)
        rb_q[i] <= 32'h0;
    end
    else
    begin
      fault_taken <= hit;
      // A new fault wins over a clear in the same cycle.
      if (hit)
        pending_q <= 1'b1;
      else if (do_clear)
        pending_q <= 1'b0;
      if (hit)
      begin
        accumulator_zero <= fault_pc;
        accumulator_one <= {27'h0, code};
        accumulator_two <= ac2_val;
        rb_q[0] <= {16'h0, processor_status_word};
        rb_q[1] <= fault_pc;
        rb_q[2] <= {27'h0, code};
        rb_q[3] <= ac2_val;
        rb_q[4] <= accumulator_three_in;
        rb_q[5] <= pc_word;
        // Untranslated faults vector through the physical segment 0 slot.
        handler_physical <= !xlat_on_q;
        handler_vector_loc <= `PFR_PZ_PROT_HANDLR;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Page zero shadow of segment 0 vectors
  // --------------------------------------------------------------------------
  // Slot order: level, I/O, page fault, context base, gates, protection.
  function [5:0] pz_loc;
    input [2:0] idx;
    begin
      case (idx)
        3'h0:    pz_loc = `PFR_PZ_INT_LEVEL;
        3'h1:    pz_loc = `PFR_PZ_IO_HANDLER;
        3'h2:    pz_loc = `PFR_PZ_PF_HANDLER;
        3'h3:    pz_loc = `PFR_PZ_CTX_BASE;
        3'h4:    pz_loc = `PFR_PZ_GATE_ARRAY;
        3'h5:    pz_loc = `PFR_PZ_PROT_HANDLR;
        default: pz_loc = `PFR_PZ_LAST;
      endcase
    end
  endfunction

  wire wr = psel && penable && pwrite;
  wire pz_dat_wr = wr && (paddr == `PFR_A_PZ_DATA);
  // Narrow handler words are truncated to the first 64 Kbytes.
  wire [31:0] pz_wval = (pz_idx_q == 3'h1 || pz_idx_q == 3'h5) ?
                        (pwdata & `PFR_NARROW_LIMIT) : pwdata;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xlat_on_q <= 1'b0;
      unimp_mask_q <= 32'h0;
      pz_idx_q <= 3'h0;
      base_level <= 1'b1;
      for (j = 0; j < 8; j = j + 1)
        pz_q[j] <= 32'h0;
    end
    else
    begin
      if (ctrl_wr)
        xlat_on_q <= pwdata[`PFR_CTRL_XLAT];
      if (wr && paddr == `PFR_A_UNIMP)
        unimp_mask_q <= pwdata;
      if (wr && paddr == `PFR_A_PZ_WORD)
        pz_idx_q <= pwdata[2:0];
      if (pz_dat_wr)
        pz_q[pz_idx_q] <= pz_wval;
      if (pz_dat_wr && pz_idx_q == 3'h0)
        base_level <= (pwdata == 32'h0);
    end
  end

  // --------------------------------------------------------------------------
  // APB read side
  // --------------------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Read data is captured in the setup cycle, so it stands from a flop for the
  // whole access phase; a fault taken at that same edge shows on the next read.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable)
    begin
      case (paddr)
        `PFR_A_CTRL:     prdata <= {31'h0, xlat_on_q};
        `PFR_A_STATUS:   prdata <= {26'h0, handler_vector_loc[4:0] == 5'h0, pending_q,
                                    accumulator_one[3:0]};
        `PFR_A_OPC_PC:   prdata <= accumulator_zero;
        `PFR_A_OPC_ADDR: prdata <= accumulator_two;
        `PFR_A_UNIMP:    prdata <= unimp_mask_q;
        `PFR_A_PZ_WORD:  prdata <= {26'h0, pz_loc(pz_idx_q)};
        `PFR_A_PZ_DATA:  prdata <= pz_q[pz_idx_q];
        default:
        begin
          if (paddr >= `PFR_A_RB_BASE && paddr <= `PFR_A_RB_LAST)
            prdata <= rb_q[paddr[4:2]];
          else
            prdata <= 32'h0;
        end
      endcase
    end
  end

endmodule // pfr_fault_report

// ### pfr_fault_checker.sv
/* Assertions on the fault reporting block's ports.
   Assumes binding to pfr_fault_report with the clock and reset named there. */
`timescale 1ns/1ps
module pfr_fault_checker (
  input logic        pclk,
  input logic        presetn,
  input logic        priv_instr,
  input logic        io_instr,
  input logic [2:0]  cur_segment,
  input logic [31:0] segment_base_entry,
  input logic [31:0] fault_pc,
  input logic        fault_taken,
  input logic [31:0] accumulator_zero,
  input logic [31:0] accumulator_one,
  input logic [31:0] accumulator_two,
  input logic [5:0]  handler_vector_loc
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Privilege outranks the I/O check, so the I/O property excludes it.
  wire pv = priv_instr && cur_segment != 3'h0;
  wire iv = io_instr && !segment_base_entry[3];
  property p_priv; pv |=> fault_taken && accumulator_one == 32'h9 && accumulator_two == 32'h0;
  endproperty
  property p_io; !pv && iv |=> fault_taken && accumulator_one == 32'ha; endproperty
  property p_pc; fault_taken |-> accumulator_zero == $past(fault_pc); endproperty
  property p_hold; !fault_taken |-> $stable(accumulator_one); endproperty
  property p_width; accumulator_one[31:5] == 27'h0; endproperty
  property p_rsv; fault_taken |-> accumulator_one != 32'hb && accumulator_one != 32'he;
  endproperty
  property p_noaddr;
    fault_taken && accumulator_one >= 32'h9 && accumulator_one != 32'hd |-> accumulator_two == 0;
  endproperty
  property p_vec; handler_vector_loc == 6'h1e; endproperty
  a_priv: assert property (p_priv)
    else $error("privileged fault wrong");
  a_io: assert property (p_io)
    else $error("io fault wrong");
  a_pc: assert property (p_pc)
    else $error("faulting pc wrong");
  a_hold: assert property (p_hold)
    else $error("code changed without fault");
  a_width: assert property (p_width)
    else $error("code not zero extended");
  a_rsv: assert property (p_rsv)
    else $error("reserved code used");
  a_noaddr: assert property (p_noaddr)
    else $error("address on no-address code");
  a_vec: assert property (p_vec)
    else $error("handler location wrong");
  c_priv: cover property (pv ##1 fault_taken);
  c_unimp: cover property (fault_taken && accumulator_one == 32'hd);
  c_valid: cover property (fault_taken && accumulator_one == 32'h3);
endmodule // pfr_fault_checker

bind pfr_fault_report pfr_fault_checker chk_u (.pclk, .presetn, .priv_instr, .io_instr,
  .cur_segment, .segment_base_entry, .fault_pc, .fault_taken, .accumulator_zero,
  .accumulator_one, .accumulator_two, .handler_vector_loc);

// ### pfr_os_handler.sv
/* Model of the fault handler software's forwarding decision.
   Assumes the bench hands it the handler word it read from page zero. */
`timescale 1ns/1ps
module pfr_os_handler (
  input  logic        pclk,
  input  logic        fault_taken,
  input  logic [31:0] handler_word,
  output logic        notify
);
  // ----------
  // Forwarding
  // ----------
  // A zero handler word means the segment opted out of notification.
  always @(posedge pclk)
    notify <= fault_taken && handler_word != 32'h0;
endmodule // pfr_os_handler

// ### testbench.sv
/* Self-checking bench for the protection fault reporting block.
   Assumes the zero-wait APB slave and one-cycle fault answer of the design. */
`timescale 1ns/1ps
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, opc_valid = 0;
  logic        opc_fallback = 0, acc_read = 0, acc_write = 0, acc_exec = 0, inner_data_ref = 0;
  logic        gate_bad = 0, outward_call = 0, inward_return = 0, priv_instr = 0, io_instr = 0;
  logic        micro_rb_bad = 0, gfx_form_bad = 0, gfx_attr_bad = 0, gfx_blit_bad = 0;
  logic        carry_in = 0, map_entry_checked = 1, pready, pslverr, fault_taken;
  logic        handler_physical, base_level, notify;
  logic [2:0]  cur_segment = 0;
  logic [4:0]  defer_depth = 0;
  logic [5:0]  handler_vector_loc;
  logic [11:0] paddr = 0;
  logic [15:0] opc_value = 0, processor_status_word = 0;
  logic [31:0] pwdata = 0, page_map_entry = 32'h1f, segment_base_entry = 32'h9, fault_pc = 0;
  logic [31:0] fault_addr = 32'h0123_4560, accumulator_three_in = 0, prdata, rdat, hword = 0;
  logic [31:0] accumulator_zero, accumulator_one, accumulator_two;
  int          n_mismatch = 0, tests_run = 0;
  pfr_fault_report dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .opc_valid, .opc_value, .opc_fallback, .acc_read, .acc_write, .acc_exec,
    .page_map_entry, .segment_base_entry, .map_entry_checked, .inner_data_ref, .defer_depth,
    .gate_bad, .outward_call, .inward_return, .priv_instr, .cur_segment, .io_instr,
    .micro_rb_bad, .gfx_form_bad, .gfx_attr_bad, .gfx_blit_bad, .fault_pc, .fault_addr,
    .processor_status_word, .accumulator_three_in, .carry_in, .fault_taken, .accumulator_zero,
    .accumulator_one, .accumulator_two, .handler_physical, .handler_vector_loc, .base_level);
  pfr_os_handler os_u (.pclk, .fault_taken, .handler_word(hword), .notify);
  initial forever #25 pclk = ~pclk;
  // ----------
  // Helpers
  // ----------
  task chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Starts one edge on, so two transfers never assign psel in one step.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rdat = prdata;
    {psel, penable} <= 2'b00;
    #1;
    chk(i < 16, "apb timeout");
    if (i == 16)
      final_report();
  endtask
  // The cause was set after the previous edge; it is sampled at the next.
  task go;
    @(posedge pclk);
    {opc_valid, opc_fallback, acc_read, acc_write, acc_exec, inner_data_ref} <= 6'h0;
    {gate_bad, outward_call, inward_return, priv_instr, io_instr, micro_rb_bad} <= 6'h0;
    {gfx_form_bad, gfx_attr_bad, gfx_blit_bad} <= 3'h0;
    {page_map_entry, segment_base_entry, defer_depth, cur_segment} <= {32'h1f, 32'h9, 8'h0};
    #1;
  endtask
  task fchk(input logic [31:0] c, input logic [31:0] a2, input string m);
    chk(fault_taken === 1'b1 && accumulator_one === c && accumulator_two === a2, m);
  endtask
  // ----------
  // Scenarios
  // ----------
  task t_table;
    int code [15];
    code = '{4, 5, 6, 7, 8, 12, 15, 16, 17, 0, 1, 2, 3, 9, 10};
    for (int k = 0; k < 15; k++)
    begin
      @(posedge pclk);
      fault_pc <= 32'h2000 + k;
      case (k)
        0: inner_data_ref <= 1'b1;
        1: defer_depth <= 5'd16;
        2: gate_bad <= 1'b1;
        3: outward_call <= 1'b1;
        4: inward_return <= 1'b1;
        5: micro_rb_bad <= 1'b1;
        6: gfx_form_bad <= 1'b1;
        7: gfx_attr_bad <= 1'b1;
        8: gfx_blit_bad <= 1'b1;
        9: {acc_read, page_map_entry} <= {1'b1, 32'h1b};
        10: {acc_write, page_map_entry} <= {1'b1, 32'h17};
        11: {acc_exec, page_map_entry} <= {1'b1, 32'h0f};
        12: {acc_read, segment_base_entry} <= {1'b1, 32'h8};
        13: {priv_instr, cur_segment} <= {1'b1, 3'h3};
        default: {io_instr, segment_base_entry} <= {1'b1, 32'h1};
      endcase
      go();
      fchk(code[k], (k < 5 || (k > 8 && k < 13)) ? fault_addr : 32'h0, "fault code");
      chk(accumulator_zero === 32'h2000 + k, "faulting pc");
    end
  endtask
  task t_prio;
    @(posedge pclk);
    {priv_instr, cur_segment, io_instr, segment_base_entry} <= {4'hd, 1'b1, 32'h1};
    go();
    fchk(32'h9, 32'h0, "priv over io");
    @(posedge pclk);
    {priv_instr, io_instr, segment_base_entry} <= {2'b11, 32'h1};
    go();
    fchk(32'ha, 32'h0, "io in segment 0");
    @(posedge pclk);
    {inner_data_ref, acc_write, page_map_entry} <= {2'b11, 32'h17};
    go();
    fchk(32'h4, fault_addr, "inner over write");
    @(posedge pclk);
    defer_depth <= 5'd15;
    go();
    chk(fault_taken === 1'b0, "depth 15 faulted");
  endtask
  task t_unimp;
    apb(1'b1, 12'h040, 32'h8);
    @(posedge pclk);
    {opc_valid, opc_value} <= {1'b1, 16'h0004};
    go();
    chk(fault_taken === 1'b0, "implemented opcode faulted");
    @(posedge pclk);
    {opc_valid, opc_value} <= {1'b1, 16'h0003};
    go();
    fchk(32'hd, 32'h0, "unimplemented opcode");
    chk(handler_physical === 1'b1, "physical handler");
    @(posedge pclk);
    {opc_valid, opc_fallback, opc_value} <= {2'b11, 16'h0023};
    go();
    fchk(32'hd, 32'h23, "fallback opcode");
  endtask
  task t_rblock;
    logic [31:0] e [6];
    @(posedge pclk);
    {processor_status_word, accumulator_three_in, carry_in} <= {16'ha5c3, 32'h3333_0003, 1'b1};
    {gate_bad, fault_pc} <= {1'b1, 32'h4440};
    go();
    e = '{32'ha5c3, 32'h4440, 32'h6, fault_addr, 32'h3333_0003, 32'h1};
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 12'(32'h20 + 4 * i), 32'h0);
      chk((i < 5 ? rdat : rdat & 32'h1) === e[i], "return block");
    end
  endtask
  task t_pzero;
    apb(1'b1, 12'h044, 32'h5);
    apb(1'b1, 12'h048, 32'h0001_2345);
    apb(1'b0, 12'h048, 32'h0);
    chk(rdat === 32'h2345, "narrow handler");
    for (int j = 0; j < 2; j++)
    begin
      hword = j ? 32'h0 : rdat;
      @(posedge pclk);
      gate_bad <= 1'b1;
      go();
      @(posedge pclk);
      #1;
      chk(notify === (j == 0), "forwarding");
    end
    apb(1'b1, 12'h044, 32'h0);
    apb(1'b1, 12'h048, 32'h1);
    chk(base_level === 1'b0, "nested level");
    apb(1'b1, 12'h048, 32'h0);
    chk(base_level === 1'b1, "base level");
    apb(1'b0, 12'h0fc, 32'h0);
    chk(rdat === 32'h0 && pslverr === 1'b0, "unmapped read");
  endtask
  task t_ctrl;
    apb(1'b1, 12'h000, 32'h1);
    @(posedge pclk);
    {priv_instr, cur_segment, carry_in, fault_pc} <= {4'hf, 1'b1, 32'h8765_4320};
    go();
    fchk(32'h9, 32'h0, "priv with translation on");
    chk(handler_physical === 1'b0, "translated handler");
    apb(1'b0, 12'h034, 32'h0);
    chk(rdat === 32'h8765_4321, "priv pc in word six");
    apb(1'b0, 12'h008, 32'h0);
    chk(rdat === 32'h8765_4320, "pc register");
    apb(1'b0, 12'h004, 32'h0);
    chk(rdat === 32'h19, "pending status");
    apb(1'b1, 12'h000, 32'h2);
    apb(1'b0, 12'h004, 32'h0);
    chk(rdat === 32'h09, "status after clear");
    apb(1'b0, 12'h000, 32'h0);
    chk(rdat === 32'h0, "translation off");
    @(posedge pclk);
    {map_entry_checked, acc_read, page_map_entry} <= {2'b01, 32'h1a};
    go();
    chk(fault_taken === 1'b0, "unchecked entry faulted");
    @(posedge pclk);
    map_entry_checked <= 1'b1;
  endtask
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(handler_vector_loc === 6'h1e && base_level === 1'b1, "reset state");
    t_table();
    t_prio();
    t_unimp();
    t_rblock();
    t_pzero();
    t_ctrl();
    final_report();
  end
endmodule // testbench
